/* File: cbt_can_bit_timing.sv */
// Contract
// - Core clock from oscillator or bus clock
// - No clock generator: oscillator clock only
// - Prescaler divides core clock into quanta
// - Every bit starts with one-quantum sync slot
// - Segment one programmable 4 to 16
// - Segment two programmable 2 to 8
// - Bit is sync, segment one, segment two
// - New transmit bit at transmit point
// - Sample at sample point, third of three
// - Jump width programmable 1 to 4
// - Fields hold length minus one
// - Listen-only: receive, recessive, never transmit
// - Listen-only: own dominant looped back internally
// - Loopback: tx to rx, pin recessive
// - Loopback: own frame received, ack ignored
// - Enable low stops all clocks (here: timing logic stops, register access keeps running)
// - Sleep keeps only register access clocks (here: wake-up detection keeps running too)
// - Power-down stops every clock (here: register writes are not stored, reads are still answered)
// - Wake interrupt needs sleep, wake enables
// - Mode chosen from CPU state, bits
// - Run mode: sleep only, no power-down
// - Pin recessive in power-down or init
// - Timing, control one writable in init only
`timescale 1ns/100ps
`default_nettype none
module cbt_can_bit_timing import cbt_pkg::*; #(
	parameter bit HAS_CLK_GEN = 1'b1, // Clock and reset generator present
	parameter int PRE_W = 6 // Prescaler field width
) (
	input wire logic clk, // 25 MHz clock
	input wire logic rst, // Async reset, high
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read valid
	input wire logic s_axi_rready, // Read ready
	input wire logic oscTick, // Oscillator clock enable pulse
	input wire logic [1:0] cpuMode, // CPU run, wait, stop3, stop1/2
	input wire logic busIdle, // Protocol layer sees bus idle
	input wire logic txBitIn, // Next bit from protocol layer
	output logic rxBit, // Sampled bit to protocol layer
	output logic samplePulse, // Sample point pulse
	output logic txPointPulse, // Transmit point pulse
	output logic txAllowed, // Protocol may start a frame
	output logic ackIgnore, // Protocol ignores ack slot
	output logic wakeIrq, // Wake-up interrupt, level
	input wire logic busReceivePin, // CAN receive pin
	output logic busTransmitPin // CAN transmit pin
);
	// Parameter check
	initial begin
		if (PRE_W < 1 || PRE_W > 6) begin
			$error("PRE_W must lie between 1 and 6");
		end
	end

	logic [7:0] ctrl0_ff, ctrl1_ff, btr0_ff, btr1_ff;
	logic initAck_ff, sleepAck_ff, wakeSeen_ff;
	logic rxMeta_ff, rxSync_ff;
	logic [PRE_W-1:0] preCnt_ff;
	logic tqPulse_ff;
	cbt_seg_e seg_ff;
	logic [4:0] qCnt_ff, seg1End_ff, seg2End_ff;
	logic [2:0] smp_ff;
	logic busPrev_ff, txReg_ff;
	logic awHeld_ff, wHeld_ff;
	logic [7:0] awAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;

	// Clamp encoded lengths to their legal ranges
	function automatic logic [4:0] seg1Len(input logic [3:0] f);
		seg1Len = (f < CBT_SEG1_MIN) ? {1'b0, CBT_SEG1_MIN} + 5'h01 : {1'b0, f} + 5'h01;
	endfunction
	function automatic logic [4:0] seg2Len(input logic [2:0] f);
		seg2Len = (f < CBT_SEG2_MIN) ? {2'b00, CBT_SEG2_MIN} + 5'h01 : {2'b00, f} + 5'h01;
	endfunction
	function automatic logic [4:0] minU(input logic [4:0] a, input logic [4:0] b);
		minU = (a < b) ? a : b;
	endfunction
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == CBT_OFF_CTRL0) || (a == CBT_OFF_CTRL1) || (a == CBT_OFF_BTR0) ||
			(a == CBT_OFF_BTR1) || (a == CBT_OFF_STAT);
	endfunction

	// Decoded control bits
	logic init_request, sleep_request, wupEn, stopWait, modEn, clkSel, listenOnly, loopBack, wakeup_interrupt_enable;
	logic tripleSmp;
	logic [4:0] sjwLen, s1Len, s2Len;
	assign init_request = ctrl0_ff[CBT_C0_INIT_REQUEST];
	assign sleep_request = ctrl0_ff[CBT_C0_SLEEP_REQUEST];
	assign wupEn = ctrl0_ff[CBT_C0_WUPEN];
	assign stopWait = ctrl0_ff[CBT_C0_STOPWAIT];
	assign modEn = ctrl1_ff[CBT_C1_ENABLE];
	assign clkSel = ctrl1_ff[CBT_C1_CLKSEL] & HAS_CLK_GEN;
	assign listenOnly = ctrl1_ff[CBT_C1_LISTEN];
	assign loopBack = ctrl1_ff[CBT_C1_LOOP];
	assign wakeup_interrupt_enable = ctrl1_ff[CBT_C1_WAKEUP_INTERRUPT_ENABLE];
	assign tripleSmp = btr1_ff[CBT_B1_TRIPLE];
	assign sjwLen = {3'b000, btr0_ff[CBT_B0_SJW_LSB +: 2]} + 5'h01;
	assign s1Len = seg1Len(btr1_ff[CBT_B1_SEG1_LSB +: 4]);
	assign s2Len = seg2Len(btr1_ff[CBT_B1_SEG2_LSB +: 3]);

	// Operating mode from CPU state and handshake bits
	logic sleepOn, powerDown, initOn, runClk;
	assign sleepOn = sleep_request & sleepAck_ff;
	always_comb begin
		case (cpuMode)
			CBT_CPU_RUN: powerDown = 1'b0;
			CBT_CPU_WAIT: powerDown = stopWait;
			CBT_CPU_STOP3: powerDown = ~sleepOn;
			CBT_CPU_STOP12: powerDown = 1'b1;
			default: powerDown = 1'b1;
		endcase
	end
	assign initOn = init_request & initAck_ff;
	// Timing logic runs only when enabled and fully awake
	assign runClk = modEn & ~sleepOn & ~powerDown & ~initOn;

	// Core clock enable from the selected source
	logic coreTick;
	assign coreTick = runClk & (clkSel | oscTick);

	// Receive pin synchroniser
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxMeta_ff <= 1'b1;
			rxSync_ff <= 1'b1;
		end else begin
			rxMeta_ff <= busReceivePin;
			rxSync_ff <= rxMeta_ff;
		end
	end

	// Bus level seen by the timing logic
	logic busNow;
	always_comb begin
		if (loopBack) begin
			busNow = txReg_ff;
		end else if (listenOnly) begin
			busNow = rxSync_ff & txReg_ff;
		end else begin
			busNow = rxSync_ff;
		end
	end

	// Prescaler, one quantum pulse per division
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			preCnt_ff <= '0;
			tqPulse_ff <= 1'b0;
		end else if (!runClk) begin
			preCnt_ff <= '0;
			tqPulse_ff <= 1'b0;
		end else begin
			tqPulse_ff <= 1'b0;
			if (coreTick) begin
				if (preCnt_ff == btr0_ff[CBT_B0_PRE_LSB +: PRE_W]) begin
					preCnt_ff <= '0;
					tqPulse_ff <= 1'b1;
				end else begin
					preCnt_ff <= preCnt_ff + 1'b1;
				end
			end
		end
	end

	// Falling edge seen at a quantum
	logic syncEdge;
	assign syncEdge = tqPulse_ff & busPrev_ff & ~busNow;

	// Bit timing state machine with resynchronisation
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seg_ff <= CBT_SYNC;
			qCnt_ff <= '0;
			seg1End_ff <= '0;
			seg2End_ff <= '0;
		end else if (!runClk) begin
			seg_ff <= CBT_SYNC;
			qCnt_ff <= '0;
		end else if (tqPulse_ff) begin
			case (seg_ff)
				CBT_SYNC: begin
					seg_ff <= CBT_SEG_ONE;
					qCnt_ff <= '0;
					seg1End_ff <= s1Len;
					seg2End_ff <= s2Len;
				end
				CBT_SEG_ONE: begin
					if (syncEdge && busIdle) begin
						qCnt_ff <= '0; // Hard sync restarts segment one
						seg1End_ff <= s1Len;
					end else begin
						if (syncEdge) begin
							seg1End_ff <= seg1End_ff + minU(qCnt_ff + 5'h01, sjwLen);
						end
						if (qCnt_ff == seg1End_ff - 5'h01) begin
							seg_ff <= CBT_SEG_TWO;
							qCnt_ff <= '0;
						end else begin
							qCnt_ff <= qCnt_ff + 5'h01;
						end
					end
				end
				CBT_SEG_TWO: begin
					if (syncEdge && (seg2End_ff - qCnt_ff) <= sjwLen) begin
						seg_ff <= CBT_SEG_ONE;
						qCnt_ff <= '0;
						seg1End_ff <= s1Len;
						seg2End_ff <= s2Len;
					end else if (syncEdge) begin
						seg2End_ff <= seg2End_ff - sjwLen;
						qCnt_ff <= qCnt_ff + 5'h01;
					end else if (qCnt_ff >= seg2End_ff - 5'h01) begin
						seg_ff <= CBT_SYNC;
						qCnt_ff <= '0;
					end else begin
						qCnt_ff <= qCnt_ff + 5'h01;
					end
				end
				default: begin
					seg_ff <= CBT_SYNC;
					qCnt_ff <= '0;
				end
			endcase
		end
	end

	// Sample point reached at the end of segment one
	logic atSample, atTxPoint, majority;
	assign atSample = tqPulse_ff && (seg_ff == CBT_SEG_ONE) && !(syncEdge && busIdle) &&
		(qCnt_ff == seg1End_ff - 5'h01);
	assign atTxPoint = tqPulse_ff && (seg_ff == CBT_SYNC);
	assign majority = (smp_ff[1] & smp_ff[0]) | (smp_ff[1] & busNow) | (smp_ff[0] & busNow);

	// Sampling, single or triple
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			smp_ff <= 3'h7;
			busPrev_ff <= 1'b1;
			rxBit <= 1'b1;
			samplePulse <= 1'b0;
		end else begin
			samplePulse <= atSample;
			if (tqPulse_ff) begin
				busPrev_ff <= busNow;
				smp_ff <= {smp_ff[1:0], busNow};
			end
			if (atSample) begin
				rxBit <= tripleSmp ? majority : busNow;
			end
		end
	end

	// Transmit register loads at the transmit point
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txReg_ff <= 1'b1;
			txPointPulse <= 1'b0;
		end else if (!runClk) begin
			txReg_ff <= 1'b1;
			txPointPulse <= 1'b0;
		end else begin
			txPointPulse <= atTxPoint;
			if (atTxPoint) begin
				txReg_ff <= txBitIn;
			end
		end
	end

	// Transmit pin, recessive outside normal driving
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busTransmitPin <= 1'b1;
		end else if (powerDown || init_request || !runClk) begin
			busTransmitPin <= 1'b1;
		end else if (loopBack || listenOnly) begin
			busTransmitPin <= 1'b1;
		end else begin
			busTransmitPin <= txReg_ff;
		end
	end

	// Mode flags for the protocol layer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txAllowed <= 1'b0;
			ackIgnore <= 1'b0;
		end else begin
			txAllowed <= runClk & ~listenOnly;
			ackIgnore <= loopBack;
		end
	end

	// Sleep and init acknowledge, wake-up activity
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			initAck_ff <= 1'b1;
			sleepAck_ff <= 1'b0;
			wakeSeen_ff <= 1'b0;
			wakeIrq <= 1'b0;
		end else begin
			initAck_ff <= init_request & modEn | init_request & initAck_ff;
			sleepAck_ff <= sleep_request & (sleepAck_ff | busIdle) & modEn;
			if (sleepOn && wupEn && !rxSync_ff) begin
				wakeSeen_ff <= 1'b1;
			end else if (!sleepOn) begin
				wakeSeen_ff <= 1'b0;
			end
			wakeIrq <= sleepOn & wupEn & wakeup_interrupt_enable & wakeSeen_ff;
		end
	end

	// AXI write channel
	logic wrGo, cfgOpen;
	assign wrGo = awHeld_ff & wHeld_ff & ~s_axi_bvalid;
	assign cfgOpen = initOn & ~powerDown;
	assign s_axi_awready = ~awHeld_ff;
	assign s_axi_wready = ~wHeld_ff;
	// Address and data capture, one response per write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			awAddr_ff <= '0;
			wData_ff <= '0;
			wStrb_ff <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CBT_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !awHeld_ff) begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !wHeld_ff) begin
				wHeld_ff <= 1'b1;
				wData_ff <= s_axi_wdata;
				wStrb_ff <= s_axi_wstrb;
			end
			if (wrGo) begin
				awHeld_ff <= 1'b0;
				wHeld_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(awAddr_ff) ? CBT_RESP_OKAY : CBT_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register stores; only byte lane zero carries data
	logic wrLane;
	assign wrLane = wrGo & wStrb_ff[0] & ~powerDown;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl0_ff <= CBT_RST_CTRL0;
			ctrl1_ff <= CBT_RST_CTRL1;
			btr0_ff <= CBT_RST_BTR0;
			btr1_ff <= CBT_RST_BTR1;
		end else if (wrLane) begin
			case (awAddr_ff)
				CBT_OFF_CTRL0: begin
					ctrl0_ff[CBT_C0_WUPEN] <= wData_ff[CBT_C0_WUPEN];
					ctrl0_ff[CBT_C0_STOPWAIT] <= wData_ff[CBT_C0_STOPWAIT];
					// Request bits may drop only once acknowledged
					if (wData_ff[CBT_C0_INIT_REQUEST] || initAck_ff || ~init_request) begin
						ctrl0_ff[CBT_C0_INIT_REQUEST] <= wData_ff[CBT_C0_INIT_REQUEST];
					end
					if (wData_ff[CBT_C0_SLEEP_REQUEST] || sleepAck_ff || ~sleep_request) begin
						ctrl0_ff[CBT_C0_SLEEP_REQUEST] <= wData_ff[CBT_C0_SLEEP_REQUEST];
					end
				end
				CBT_OFF_CTRL1: begin
					if (cfgOpen) begin
						ctrl1_ff <= wData_ff[7:0];
					end
				end
				CBT_OFF_BTR0: begin
					if (cfgOpen) begin
						btr0_ff <= wData_ff[7:0];
					end
				end
				CBT_OFF_BTR1: begin
					if (cfgOpen) begin
						btr1_ff <= wData_ff[7:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Read data assembly
	logic [2:0] modeCode;
	logic [7:0] rdByte;
	always_comb begin
		if (!modEn) begin
			modeCode = CBT_MD_DISABLED;
		end else if (powerDown) begin
			modeCode = CBT_MD_POWERDOWN;
		end else if (initOn) begin
			modeCode = CBT_MD_INIT;
		end else if (sleepOn) begin
			modeCode = CBT_MD_SLEEP;
		end else begin
			modeCode = CBT_MD_NORMAL;
		end
		rdByte = 8'h00;
		case (s_axi_araddr)
			CBT_OFF_CTRL0: begin
				rdByte = ctrl0_ff;
				rdByte[CBT_C0_INITACK] = initAck_ff;
				rdByte[CBT_C0_SLPACK] = sleepAck_ff;
			end
			CBT_OFF_CTRL1: rdByte = ctrl1_ff;
			CBT_OFF_BTR0: rdByte = btr0_ff;
			CBT_OFF_BTR1: rdByte = btr1_ff;
			CBT_OFF_STAT: begin
				rdByte[CBT_ST_MODE_LSB +: 3] = modeCode;
				rdByte[CBT_ST_RXBIT] = rxBit;
				rdByte[CBT_ST_WAKESEEN] = wakeSeen_ff;
				rdByte[CBT_ST_WAKEIRQ] = wakeIrq;
			end
			default: rdByte = 8'h00;
		endcase
	end

	// AXI read channel, one cycle answer
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= CBT_RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rdByte};
			s_axi_rresp <= mapped(s_axi_araddr) ? CBT_RESP_OKAY : CBT_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: cbt_pkg.sv */
package cbt_pkg;
	// Register byte offsets
	localparam logic [7:0] CBT_OFF_CTRL0 = 8'h00;
	localparam logic [7:0] CBT_OFF_CTRL1 = 8'h04;
	localparam logic [7:0] CBT_OFF_BTR0 = 8'h08;
	localparam logic [7:0] CBT_OFF_BTR1 = 8'h0c;
	localparam logic [7:0] CBT_OFF_STAT = 8'h10;
	// Control register zero fields
	localparam int CBT_C0_INIT_REQUEST = 0;
	localparam int CBT_C0_SLEEP_REQUEST = 1;
	localparam int CBT_C0_WUPEN = 2;
	localparam int CBT_C0_STOPWAIT = 3;
	localparam int CBT_C0_INITACK = 4;
	localparam int CBT_C0_SLPACK = 5;
	// Control register one fields
	localparam int CBT_C1_ENABLE = 0;
	localparam int CBT_C1_CLKSEL = 1;
	localparam int CBT_C1_LISTEN = 2;
	localparam int CBT_C1_LOOP = 3;
	localparam int CBT_C1_WAKEUP_INTERRUPT_ENABLE = 4;
	// Bit timing fields
	localparam int CBT_B0_PRE_LSB = 0;
	localparam int CBT_B0_SJW_LSB = 6;
	localparam int CBT_B1_SEG1_LSB = 0;
	localparam int CBT_B1_SEG2_LSB = 4;
	localparam int CBT_B1_TRIPLE = 7;
	// Status fields
	localparam int CBT_ST_MODE_LSB = 0;
	localparam int CBT_ST_RXBIT = 3;
	localparam int CBT_ST_WAKESEEN = 4;
	localparam int CBT_ST_WAKEIRQ = 5;
	// Reset values
	localparam logic [7:0] CBT_RST_CTRL0 = 8'h11;
	localparam logic [7:0] CBT_RST_CTRL1 = 8'h00;
	localparam logic [7:0] CBT_RST_BTR0 = 8'h00;
	localparam logic [7:0] CBT_RST_BTR1 = 8'h00;
	// Encoded segment limits (length minus one)
	localparam logic [3:0] CBT_SEG1_MIN = 4'h3;
	localparam logic [2:0] CBT_SEG2_MIN = 3'h1;
	// Mode codes shown in the status register
	localparam logic [2:0] CBT_MD_DISABLED = 3'h0;
	localparam logic [2:0] CBT_MD_INIT = 3'h1;
	localparam logic [2:0] CBT_MD_POWERDOWN = 3'h2;
	localparam logic [2:0] CBT_MD_SLEEP = 3'h3;
	localparam logic [2:0] CBT_MD_NORMAL = 3'h4;
	// CPU operating modes
	localparam logic [1:0] CBT_CPU_RUN = 2'h0;
	localparam logic [1:0] CBT_CPU_WAIT = 2'h1;
	localparam logic [1:0] CBT_CPU_STOP3 = 2'h2;
	localparam logic [1:0] CBT_CPU_STOP12 = 2'h3;
	// AXI responses
	localparam logic [1:0] CBT_RESP_OKAY = 2'h0;
	localparam logic [1:0] CBT_RESP_SLVERR = 2'h2;
	// Bit timing states
	typedef enum logic [1:0] {CBT_SYNC, CBT_SEG_ONE, CBT_SEG_TWO} cbt_seg_e;
endpackage

/* File: cbt_bus_node.sv */
`timescale 1ns/100ps
`default_nettype none
// Remote node on a wired-AND bus behind the line transceiver
module cbt_bus_node (
	input wire logic busTransmitPin, // Device transmit pin
	input wire logic nodeBit, // Remote node bit, 0 dominant
	output logic busReceivePin // Bus level seen by device
);
	// Dominant level wins on the shared line
	assign busReceivePin = busTransmitPin & nodeBit;
endmodule
`default_nettype wire

/* File: cbt_can_bit_timing_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module cbt_can_bit_timing_properties import cbt_pkg::*; (
	input wire logic clk, // Clock
	input wire logic rst, // Async reset, high
	input wire logic [1:0] s_axi_bresp, // Write response
	input wire logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic s_axi_rvalid, // Read valid
	input wire logic s_axi_rready, // Read ready
	input wire logic [1:0] cpuMode, // CPU mode
	input wire logic samplePulse, // Sample point pulse
	input wire logic txPointPulse, // Transmit point pulse
	input wire logic txAllowed, // Frame start allowed
	input wire logic busTransmitPin // CAN transmit pin
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Bit timing shape
	a_sample_single: assert property (samplePulse |=> !samplePulse)
		else $error("sample pulse longer than one cycle");
	a_bit_gap: assert property (txPointPulse |=> !txPointPulse[*6])
		else $error("bit shorter than seven quanta");
	a_seg_one: assert property (txPointPulse |-> !samplePulse[*4])
		else $error("sample point inside first four quanta");
	a_dominant_at_tp: assert property ($fell(busTransmitPin) |-> txPointPulse || $past(txPointPulse))
		else $error("transmit pin went dominant away from transmit point");
	// Power-down keeps the pin and timing quiet
	a_pd_quiet: assert property ((cpuMode == CBT_CPU_STOP12)[*3] |-> busTransmitPin && !txPointPulse)
		else $error("activity on pin in power-down");
	a_pd_no_frame: assert property ((cpuMode == CBT_CPU_STOP12)[*3] |-> !txAllowed && !samplePulse)
		else $error("frame allowed in power-down");
	// Register access path keeps answering
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before ready");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before ready");
	// Main scenarios reached
	c_tx_point: cover property (txPointPulse);
	c_dominant: cover property (samplePulse && !busTransmitPin);
	c_power_down: cover property ((cpuMode == CBT_CPU_STOP12)[*3]);
endmodule
bind cbt_can_bit_timing cbt_can_bit_timing_properties u_chk (.*);
`default_nettype wire

/* File: cbt_can_bit_timing_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module cbt_can_bit_timing_tb_top import cbt_pkg::*;;
	logic clk = 1'h0, rst = 1'h1;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, cpuMode = 2'h0, oscCnt = 2'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic oscTick = 1'h0, busIdle = 1'h1, txBitIn = 1'h1, nodeBit = 1'h1, tb = 1'h1;
	logic rxBit, samplePulse, txPointPulse, txAllowed, ackIgnore, wakeIrq, busReceivePin, busTransmitPin;
	logic [1:0] cmT [6] = '{CBT_CPU_RUN, CBT_CPU_WAIT, CBT_CPU_WAIT, CBT_CPU_STOP3, CBT_CPU_STOP12, CBT_CPU_RUN};
	logic swT [6] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0};
	logic [2:0] emT [6] = '{CBT_MD_NORMAL, CBT_MD_POWERDOWN, CBT_MD_NORMAL, CBT_MD_POWERDOWN, CBT_MD_POWERDOWN,
		CBT_MD_NORMAL};
	int err_count = 0, compares = 0;
	cbt_can_bit_timing DUT (.*);
	cbt_bus_node node (.busTransmitPin(busTransmitPin), .nodeBit(nodeBit), .busReceivePin(busReceivePin));
	// 25 MHz clock
	initial forever #20 clk = ~clk;
	// Oscillator enable, one tick in three clocks
	always @(posedge clk) begin
		oscCnt <= (oscCnt == 2'h2) ? 2'h0 : oscCnt + 2'h1;
		oscTick <= (oscCnt == 2'h2);
	end
	task results;
		$display("Counts: compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Bounded wait guard
	task tmo(input int n);
		if (n > 3000) begin
			err_count++;
			$display("Error wait expected done seen timeout");
			results;
		end
	endtask
	function int mx(input int a, input int b);
		return a > b ? a : b;
	endfunction
	// AXI4-Lite write, both channels offered together
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		bit ta, td;
		n = 0;
		ta = 0;
		td = 0;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'h1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'h1;
		while (!(ta && td)) begin
			@(posedge clk);
			n++;
			tmo(n);
			if (s_axi_awready && !ta) begin
				ta = 1;
				s_axi_awvalid <= 1'h0;
			end
			if (s_axi_wready && !td) begin
				td = 1;
				s_axi_wvalid <= 1'h0;
			end
		end
		do begin
			@(posedge clk);
			n++;
			tmo(n);
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h1;
		@(posedge clk);
		chk("bresp", s_axi_bresp, er);
		s_axi_bready <= 1'h0;
	endtask
	// AXI4-Lite read
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge clk);
			n++;
			tmo(n);
		end while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do begin
			@(posedge clk);
			n++;
			tmo(n);
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h1;
		@(posedge clk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk("rdata", d, e);
		chk("rresp", r, CBT_RESP_OKAY);
	endtask
	// Wait for transmit point (0) or sample point (1)
	task wp(input bit s);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			tmo(n);
		end while ((s ? samplePulse : txPointPulse) !== 1'h1);
	endtask
	task cntp(output int n);
		n = 0;
		repeat (60) begin
			@(posedge clk);
			n += txPointPulse;
		end
	endtask
	// Enter init, program timing, leave init, then try a locked write
	task cfg(input logic [7:0] c1, input logic [7:0] b0, input logic [7:0] b1);
		logic [31:0] d;
		logic [1:0] r;
		int n;
		wr(CBT_OFF_CTRL0, 32'h1, CBT_RESP_OKAY);
		n = 0;
		do begin
			rd(CBT_OFF_CTRL0, d, r);
			n++;
			tmo(n * 500);
		end while (d[CBT_C0_INITACK] !== 1'h1);
		wr(CBT_OFF_CTRL1, c1, CBT_RESP_OKAY);
		wr(CBT_OFF_BTR0, b0, CBT_RESP_OKAY);
		wr(CBT_OFF_BTR1, b1, CBT_RESP_OKAY);
		rdc(CBT_OFF_BTR0, b0);
		rdc(CBT_OFF_BTR1, b1);
		wr(CBT_OFF_CTRL0, 32'h0, CBT_RESP_OKAY);
		n = 0;
		do begin
			rd(CBT_OFF_CTRL0, d, r);
			n++;
			tmo(n * 500);
		end while (d[CBT_C0_INITACK] !== 1'h0);
		wr(CBT_OFF_BTR1, {24'h0, ~b1}, CBT_RESP_OKAY);
		rdc(CBT_OFF_BTR1, b1);
	endtask
	// Bit length and sample position, q clocks per quantum
	task per(input int q, input int s1, input int s2);
		int n;
		wp(1'h0);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (txPointPulse !== 1'h1 && n < 3000);
		chk("bitclk", n, q * (3 + mx(s1, 3) + mx(s2, 1)));
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (samplePulse !== 1'h1 && n < 3000);
		chk("seg1clk", n, q * (mx(s1, 3) + 1));
	endtask
	// Bit traffic: m 0 normal, 1 listen-only, 2 loopback
	task traf(input int m);
		logic nb;
		for (int k = 0; k < 8; k++) begin
			wp(1'h0);
			nb = 1'($urandom % 2);
			nodeBit <= nb;
			busIdle <= 1'($urandom % 2);
			wp(1'h1);
			chk("txpin", busTransmitPin, m == 0 ? tb : 1'h1);
			repeat (2) @(posedge clk);
			chk("rxbit", rxBit, m == 2 ? tb : tb & nb);
			chk("txok", txAllowed, m != 1);
			chk("ackign", ackIgnore, m == 2);
			// Last bit recessive so the next bit-time measurement sees no edge
			tb = (k == 7) ? 1'h1 : 1'($urandom % 2);
			txBitIn <= tb;
		end
		nodeBit <= 1'h1;
		busIdle <= 1'h1;
	endtask
	// Main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int pf, sj, s1, s2, n;
		bit sel;
		void'($urandom(32'h326da6c5));
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		rdc(CBT_OFF_CTRL0, CBT_RST_CTRL0);
		rdc(CBT_OFF_CTRL1, CBT_RST_CTRL1);
		rdc(CBT_OFF_BTR0, CBT_RST_BTR0);
		rdc(CBT_OFF_BTR1, CBT_RST_BTR1);
		rd(8'h14, d, r);
		chk("unmapped", r, CBT_RESP_SLVERR);
		wr(8'h18, 32'h5, CBT_RESP_SLVERR);
		cntp(n);
		chk("offpulse", n, 0);
		for (int i = 0; i < 4; i++) begin
			pf = $urandom % 4 + 1;
			sj = $urandom % 4;
			sel = (i != 3);
			s1 = i == 0 ? 15 : 0;
			s2 = i == 0 ? 7 : 0;
			if (i > 1) begin
				s2 = $urandom % 2 + 1;
				s1 = s2 == 1 ? 4 + $urandom % 6 : 3 + $urandom % 8;
				sj = $urandom % (s2 + 1);
			end
			cfg({4'h0, (i % 3) == 2, (i % 3) == 1, sel, 1'h1}, {sj[1:0], 6'(pf)}, {i == 0, 3'(s2), 4'(s1)});
			per((pf + 1) * (sel ? 1 : 3), s1, s2);
			traf(i % 3);
		end
		cfg(8'h13, 8'h01, 8'h23);
		for (int i = 0; i < 6; i++) begin
			cpuMode <= CBT_CPU_RUN;
			repeat (4) @(posedge clk);
			wr(CBT_OFF_CTRL0, {28'h0, swT[i], 3'h0}, CBT_RESP_OKAY);
			cpuMode <= cmT[i];
			repeat (8) @(posedge clk);
			rd(CBT_OFF_STAT, d, r);
			chk("mode", d[2:0], emT[i]);
			chk("pdpin", busTransmitPin | (emT[i] != CBT_MD_POWERDOWN), 1'h1);
			chk("wake", wakeIrq, 1'h0);
		end
		cpuMode <= CBT_CPU_RUN;
		repeat (4) @(posedge clk);
		wr(CBT_OFF_CTRL0, 32'h6, CBT_RESP_OKAY);
		repeat (8) @(posedge clk);
		rdc(CBT_OFF_CTRL0, 32'h26);
		rd(CBT_OFF_STAT, d, r);
		chk("mode", d[2:0], CBT_MD_SLEEP);
		cntp(n);
		chk("slppulse", n, 0);
		cpuMode <= CBT_CPU_STOP3;
		repeat (4) @(posedge clk);
		rd(CBT_OFF_STAT, d, r);
		chk("mode", d[2:0], CBT_MD_SLEEP);
		chk("wake", wakeIrq, 1'h0);
		nodeBit <= 1'h0;
		n = 0;
		while (wakeIrq !== 1'h1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk("wake", wakeIrq, 1'h1);
		results;
	end
endmodule
`default_nettype wire
